// ### i2c_buf_ack_pkg.sv
// constants, types and register map for the buffered acknowledge controller
package i2c_buf_ack_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the wishbone port)
  // ---------------------------------------------------------------
  localparam int          ADR_W       = 4;
  localparam logic [3:0]  CTRL_OFS    = 4'h0;
  localparam logic [3:0]  COUNT_OFS   = 4'h4;
  localparam logic [3:0]  STATUS_OFS  = 4'h8;

  // control register fields
  localparam int          CTRL_MODE_BIT  = 0;
  localparam int          CTRL_ACK_BIT   = 1;
  localparam int          CTRL_NACK_BIT  = 2;
  localparam int          CTRL_GCALL_BIT = 3;
  localparam logic [3:0]  CTRL_RST       = 4'h0;

  // transfer length register field and legal range
  localparam int          COUNT_W     = 7;
  localparam logic [6:0]  COUNT_RST   = 7'h01;
  localparam logic [6:0]  COUNT_MIN   = 7'h01;
  localparam logic [6:0]  COUNT_MAX   = 7'h44;

  // status register fields
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_ADDR_BIT  = 4;
  localparam int          STAT_ILL_BIT   = 5;
  localparam int          STAT_REM_LSB   = 8;
  localparam int          STAT_CODE_LSB  = 24;
  localparam logic [7:0]  CODE_IDLE      = 8'hF8;
  localparam logic [7:0]  CODE_ILLEGAL   = 8'hFC;

  // sequence state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MTX  = 3'b001,
    ST_MRX  = 3'b010,
    ST_STX  = 3'b011,
    ST_SRX  = 3'b100
  } state_e;

  // control bits as software sees them
  typedef struct packed {
    logic general_call_enable;
    logic last_byte_nack_enable;
    logic assert_acknowledge;
    logic mode_buffered;
  } ctrl_s;

  // byte-level events from the serial engine, all one-cycle pulses
  typedef struct packed {
    logic master_start;
    logic master_read;
    logic own_addr;
    logic addr_read;
    logic byte_done;
    logic stop;
  } evt_s;

endpackage

// ### i2c_buffered_ack_control.sv
// acknowledge and addressing control for buffered i2c sequences
//
// Functional notes
// R01: master transmit sequence length equals byte_count
// R02: master receive takes byte_count bytes, then ends
// R03: nack-last clear: master receiver acks the final byte
// R04: nack-last set: master receiver nacks the final byte
// R05: ack-enable clear: own slave address is nacked
// R06: ack-enable set: own slave address is acked
// R07: slave transmit sequence length equals byte_count
// R08: slave receive sequence length equals byte_count
// R09: ack-enable clear: slave transmitter unaddressed after last byte
// R10: ack-enable clear: slave receiver unaddressed after last byte
// R11: ack-enable set: slave transmitter stays addressed throughout
// R12: nack-last clear: slave receiver acks the final byte
// R13: nack-last set: slave receiver nacks the final byte
// R14: every byte acked except a nack-last final one
// R15: byte_count must be 1..68, else flagged illegal
// R16: early stop avoids final-byte nack, ends sequence
// R17: counter loads byte_count at start, counts down
`timescale 1ns/1ps

module i2c_buffered_ack_control
  import i2c_buf_ack_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic      [31:0]       o_wb_dat,
  output logic                   o_wb_ack,
  input  wire evt_s              i_evt,
  output logic                   o_ack_drive,
  output logic                   o_addressed,
  output logic                   o_last_byte,
  output logic                   o_seq_done,
  output logic                   o_general_call_enable
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ctrl_s                ctrl_reg;
  logic [COUNT_W-1:0]   byte_count_reg;
  logic [COUNT_W-1:0]   remain_reg;
  logic [COUNT_W-1:0]   remain_next;
  state_e               state_reg;
  state_e               state_next;
  logic                 ack_reg;
  logic [31:0]          rdat_reg;
  logic                 ack_drive_reg;
  logic                 last_byte_reg;
  logic                 seq_done_reg;
  logic                 seq_done_next;
  logic                 wb_req;
  logic                 illegal_count;
  logic                 buffered;
  logic                 is_last;
  logic                 rx_state;

  // true when a byte count lies outside the legal range
  function automatic logic count_bad(input logic [COUNT_W-1:0] cnt);
    count_bad = (cnt < COUNT_MIN) || (cnt > COUNT_MAX);
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // one wait state; ack drops the cycle after it was given
  assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // control and length writes; only byte lane 0 holds bits
  // limitation: a write with sel[0] low is dropped, since the upper lanes hold nothing
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg       <= ctrl_s'(CTRL_RST);
      byte_count_reg <= COUNT_RST;
    end else if (wb_req && i_wb_we && i_wb_sel[0]) begin
      if (i_wb_adr == CTRL_OFS) begin
        ctrl_reg.mode_buffered         <= i_wb_dat[CTRL_MODE_BIT];
        ctrl_reg.assert_acknowledge    <= i_wb_dat[CTRL_ACK_BIT];
        ctrl_reg.last_byte_nack_enable <= i_wb_dat[CTRL_NACK_BIT];
        ctrl_reg.general_call_enable   <= i_wb_dat[CTRL_GCALL_BIT];
      end
      if (i_wb_adr == COUNT_OFS) begin
        byte_count_reg <= i_wb_dat[COUNT_W-1:0];
      end
    end
  end

  // read data captured with the request; unmapped reads give zero
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      rdat_reg <= 32'h0000_0000;
      unique case (i_wb_adr)
        CTRL_OFS: begin
          rdat_reg[3:0] <= ctrl_reg;
        end
        COUNT_OFS: begin
          rdat_reg[COUNT_W-1:0] <= byte_count_reg;
        end
        STATUS_OFS: begin
          rdat_reg[STAT_STATE_LSB +: 3]       <= state_reg;
          rdat_reg[STAT_ADDR_BIT]             <= o_addressed;
          rdat_reg[STAT_ILL_BIT]              <= illegal_count;  // [R15]
          rdat_reg[STAT_REM_LSB +: COUNT_W]   <= remain_reg;
          rdat_reg[STAT_CODE_LSB +: 8]        <= illegal_count ? CODE_ILLEGAL : CODE_IDLE;
        end
        default: begin
          rdat_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign o_wb_ack              = ack_reg;
  assign o_wb_dat              = rdat_reg;
  assign o_general_call_enable = ctrl_reg.general_call_enable;

  // ---------------------------------------------------------------
  // sequence state and byte counter
  // ---------------------------------------------------------------
  // an illegal count refuses new sequences rather than guessing a length
  assign illegal_count = count_bad(byte_count_reg);                   // [R15]
  assign buffered      = ctrl_reg.mode_buffered && !illegal_count;
  assign is_last       = (remain_reg == COUNT_MIN);
  assign rx_state      = (state_reg == ST_MRX) || (state_reg == ST_SRX);

  always_comb begin
    state_next    = state_reg;
    remain_next   = remain_reg;
    seq_done_next = 1'b0;
    if (i_evt.stop) begin
      // stop ends any sequence, so no final nack is ever sent early
      state_next  = ST_IDLE;                                          // [R16]
      remain_next = '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (buffered && i_evt.master_start) begin
            state_next  = i_evt.master_read ? ST_MRX : ST_MTX;        // [R01] [R02]
            remain_next = byte_count_reg;                             // [R17]
          end else if (buffered && i_evt.own_addr &&
                       ctrl_reg.assert_acknowledge) begin
            state_next  = i_evt.addr_read ? ST_STX : ST_SRX;          // [R06] [R07] [R08]
            remain_next = byte_count_reg;                             // [R17]
          end
        end
        ST_MTX, ST_MRX: begin
          if (i_evt.byte_done) begin
            remain_next = remain_reg - 7'h01;                         // [R17]
            if (is_last) begin
              state_next    = ST_IDLE;                                // [R01] [R02]
              seq_done_next = 1'b1;
            end
          end
        end
        ST_STX, ST_SRX: begin
          if (i_evt.byte_done) begin
            remain_next = remain_reg - 7'h01;
            if (is_last) begin
              seq_done_next = 1'b1;                                   // [R07] [R08]
              if (ctrl_reg.assert_acknowledge) begin
                remain_next = byte_count_reg;                         // [R11]
              end else begin
                state_next  = ST_IDLE;                                // [R09] [R10]
              end
            end
          end
        end
        default: begin
          state_next  = ST_IDLE;
          remain_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg    <= ST_IDLE;
      remain_reg   <= '0;
      seq_done_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      remain_reg   <= remain_next;
      seq_done_reg <= seq_done_next;
    end
  end

  // ---------------------------------------------------------------
  // acknowledge value for the slot after the current byte
  // ---------------------------------------------------------------
  // engine samples this one cycle after own_addr or byte_done
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_drive_reg <= 1'b0;
    end else if (i_evt.stop) begin
      ack_drive_reg <= 1'b0;                                          // [R16]
    end else if (state_reg == ST_IDLE && i_evt.own_addr) begin
      ack_drive_reg <= ctrl_reg.assert_acknowledge && buffered;       // [R05] [R06]
    end else if (rx_state && i_evt.byte_done) begin
      // the ack enable bit has no say here, only nack-last on the counted end
      ack_drive_reg <= !(is_last && ctrl_reg.last_byte_nack_enable);  // [R03] [R04] [R12] [R13] [R14]
    end
  end

  // last-byte flag lets the engine stage the final byte
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      last_byte_reg <= 1'b0;
    end else begin
      last_byte_reg <= (state_next != ST_IDLE) && (remain_next == COUNT_MIN);
    end
  end

  assign o_ack_drive = ack_drive_reg;
  assign o_last_byte = last_byte_reg;
  assign o_seq_done  = seq_done_reg;
  assign o_addressed = (state_reg == ST_STX) || (state_reg == ST_SRX);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // every check runs on the system clock and sleeps through reset
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_addr_seen;
    state_reg == ST_IDLE && i_evt.own_addr && !i_evt.stop && buffered;
  endsequence

  sequence s_rx_byte;
    rx_state && i_evt.byte_done && !i_evt.stop;
  endsequence

  sequence s_last_tx;
    (state_reg == ST_MTX || state_reg == ST_STX) && i_evt.byte_done && !i_evt.stop && is_last;
  endsequence

  a_addr_nack: assert property (s_addr_seen and !ctrl_reg.assert_acknowledge |=> // [R05]
    !o_ack_drive && !o_addressed) else $error("own address not nacked");

  a_addr_ack: assert property (s_addr_seen and ctrl_reg.assert_acknowledge |=> // [R06]
    o_ack_drive && o_addressed && remain_reg == $past(byte_count_reg))
    else $error("own address not acked");

  a_rx_last_ack: assert property (s_rx_byte and is_last && !ctrl_reg.last_byte_nack_enable // [R03] [R12]
    |=> o_ack_drive) else $error("final byte not acked");

  a_rx_last_nack: assert property (s_rx_byte and is_last && ctrl_reg.last_byte_nack_enable // [R04] [R13]
    |=> !o_ack_drive) else $error("final byte not nacked");

  a_rx_mid_ack: assert property (s_rx_byte and !is_last |=> o_ack_drive // [R14]
    ##0 remain_reg == $past(remain_reg) - 7'h01) else $error("middle byte not acked");

  a_mst_end: assert property ((state_reg == ST_MTX || state_reg == ST_MRX) // [R01] [R02]
    && i_evt.byte_done && !i_evt.stop && is_last |=> state_reg == ST_IDLE && o_seq_done)
    else $error("master sequence did not end");

  a_slv_drop: assert property (o_addressed && i_evt.byte_done && !i_evt.stop && is_last // [R09] [R10]
    && !ctrl_reg.assert_acknowledge |=> state_reg == ST_IDLE && !o_addressed)
    else $error("slave not released");

  a_stx_stay: assert property (s_last_tx and state_reg == ST_STX // [R11] [R07]
    && ctrl_reg.assert_acknowledge |=> o_addressed && remain_reg == $past(byte_count_reg))
    else $error("slave transmitter dropped");

  a_stop_clear: assert property (i_evt.stop |=> state_reg == ST_IDLE // [R16]
    && !o_ack_drive ##1 !o_seq_done) else $error("stop did not end sequence");

  a_count_load: assert property (state_reg == ST_IDLE && state_next != ST_IDLE // [R17] [R08]
    |=> remain_reg == $past(byte_count_reg) && !count_bad(remain_reg))
    else $error("counter not loaded");

  a_count_gate: assert property (illegal_count && state_reg == ST_IDLE // [R15]
    |=> state_reg == ST_IDLE) else $error("illegal count started a sequence");

  // ---------------------------------------------------------------
  // bus, counter and mode assertions
  // ---------------------------------------------------------------
  // bus handshake: one wait state, ack never stands two cycles
  a_wb_ack_late: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not acked");

  a_wb_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus ack held too long");

  // a start is only taken from idle in buffered mode with a legal count
  a_mst_start: assert property (state_reg == ST_IDLE && buffered // [R01] [R02]
    && i_evt.master_start && !i_evt.stop
    |=> state_reg == ($past(i_evt.master_read) ? ST_MRX : ST_MTX))
    else $error("master sequence not started");

  a_slv_start: assert property (s_addr_seen and ctrl_reg.assert_acknowledge // [R07] [R08]
    |=> state_reg == ($past(i_evt.addr_read) ? ST_STX : ST_SRX))
    else $error("slave role not entered");

  a_srx_stay: assert property (state_reg == ST_SRX && i_evt.byte_done && !i_evt.stop // [R08]
    && is_last && ctrl_reg.assert_acknowledge |=> o_addressed && o_seq_done)
    else $error("slave receiver dropped");

  // the last-byte flag rises as the count reaches one
  a_last_flag: assert property (state_reg != ST_IDLE && i_evt.byte_done && !i_evt.stop // [R17]
    && remain_reg == COUNT_MIN + 7'h01 |=> o_last_byte) else $error("last-byte flag missing");

  // while busy the counter only moves on a byte or a stop
  a_count_hold: assert property (state_reg != ST_IDLE && !i_evt.byte_done && !i_evt.stop // [R17]
    |=> $stable(remain_reg)) else $error("counter moved without a byte");

  // a start seen while busy is ignored; the running sequence keeps its role
  a_start_busy: assert property (state_reg != ST_IDLE && i_evt.master_start // [R17]
    && !i_evt.byte_done && !i_evt.stop |=> state_reg == $past(state_reg))
    else $error("start taken while busy");

  // every way back to idle leaves the counter empty
  a_idle_empty: assert property (state_reg == ST_IDLE // [R17]
    |-> remain_reg == 7'h00 && !o_last_byte) else $error("idle with a loaded counter");

  // a stop empties the counter and never reports a finished sequence
  a_stop_count: assert property (i_evt.stop |=> remain_reg == 7'h00 && !o_seq_done // [R16]
    && !o_last_byte) else $error("stop left the counter loaded");

  // byte mode keeps the block idle whatever the bus does
  a_byte_idle: assert property (!ctrl_reg.mode_buffered && state_reg == ST_IDLE
    |=> state_reg == ST_IDLE) else $error("byte mode left idle");

  // transmitted bytes are acked by the far side, so our ack value stays put
  a_tx_ack_keep: assert property ((state_reg == ST_MTX || state_reg == ST_STX) && !i_evt.stop
    |=> $stable(o_ack_drive)) else $error("ack value moved while transmitting");

endmodule // i2c_buffered_ack_control

// ### i2c_far_side.sv
// far-side model: other i2c masters and slaves, seen as serial engine events
`timescale 1ns/1ps

module i2c_far_side
  import i2c_buf_ack_pkg::*;
(
  input  wire logic  i_clk_sys,
  output evt_s       o_evt
);
  evt_s  evt_reg = '0;

  assign o_evt = evt_reg;

  // one-cycle event after an optional stall; idle in between, as on a quiet bus
  task automatic send(input evt_s e, input int gap);
    repeat (gap) @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    evt_reg <= e;
    @(posedge i_clk_sys);
    evt_reg <= '0;
    #1;
  endtask
endmodule // i2c_far_side

// ### test_i2c_buffered_ack_control.sv
// self-checking bench for the buffered acknowledge controller
`timescale 1ns/1ps

module test_i2c_buffered_ack_control;
  import i2c_buf_ack_pkg::*;

  // ---------------------------------------------------------------
  // stimulus signals
  // ---------------------------------------------------------------
  localparam evt_s         EV_MRX  = 6'h30;
  localparam evt_s         EV_MTX  = 6'h20;
  localparam evt_s         EV_SRX  = 6'h08;
  localparam evt_s         EV_STX  = 6'h0C;
  localparam evt_s         EV_BYTE = 6'h02;
  localparam evt_s         EV_STOP = 6'h01;
  localparam logic [31:0]  MODE    = 32'h1;
  localparam logic [31:0]  ACK_EN    = 32'h2;
  localparam logic [31:0]  NACK_LAST = 32'h4;
  localparam logic [31:0]  GCALL_EN  = 32'h8;
  logic              clk    = 1'b0;
  logic              resetn = 1'b0;
  logic              cyc    = 1'b0;
  logic              stb    = 1'b0;
  logic              we     = 1'b0;
  logic [ADR_W-1:0]  adr    = '0;
  logic [3:0]        sel    = 4'h0;
  logic [31:0]       wdat   = '0;
  logic [31:0]       rdat, rd;
  logic              ack, ack_drive, addressed, last_byte, seq_done, gcall_en;
  evt_s              evt;
  int                num_errors = 0;
  int                n_checks   = 0;
  logic [31:0]       bad [2]    = '{32'h0, 32'h45};

  i2c_buffered_ack_control DUT (.i_clk_sys(clk), .i_resetn(resetn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_evt(evt), .o_ack_drive(ack_drive),
    .o_addressed(addressed), .o_last_byte(last_byte), .o_seq_done(seq_done),
    .o_general_call_enable(gcall_en));

  i2c_far_side u_far (.i_clk_sys(clk), .o_evt(evt));

  // 25 MHz system clock
  initial forever #20 clk = ~clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, m, input string what);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got & m, exp & m);
    end
  endtask

  // outputs as {ack_drive, addressed, last_byte, seq_done}, masked
  task automatic chk_o(input logic [3:0] e, m);
    chk({28'h0, ack_drive, addressed, last_byte, seq_done}, {28'h0, e}, {28'h0, m}, "outputs");
  endtask

  // classic cycle: hold everything until ack is sampled high, never assume a latency
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk({31'h0, n < 20}, 32'h1, 32'h1, "bus ack");
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wb(1'b0, CTRL_OFS, '0);
    chk(rd, '0, '1, "ctrl reset");
    wb(1'b0, COUNT_OFS, '0);
    chk(rd, 32'h1, 32'h7F, "count reset");
    wb(1'b0, STATUS_OFS, '0);
    chk(rd, 32'hF800_0000, 32'hFF00_003F, "status reset");
    wb(1'b0, 4'hC, '0);
    chk(rd, '0, '1, "unmapped read");
    // byte mode: the own address is never taken, even with ack enabled
    wb(1'b1, CTRL_OFS, ACK_EN);
    u_far.send(EV_SRX, 0);
    chk_o(4'h0, 4'hC);
    wb(1'b1, CTRL_OFS, MODE | GCALL_EN);
    @(posedge clk);
    #1;
    chk({31'h0, gcall_en}, 32'h1, 32'h1, "general call enable");
    $display("test registers done");
    // out-of-range counts must refuse new sequences
    foreach (bad[i]) begin
      wb(1'b1, COUNT_OFS, bad[i]);
      wb(1'b0, STATUS_OFS, '0);
      chk(rd, 32'hFC00_0020, 32'hFF00_0020, "illegal count");
      u_far.send(EV_MRX, 0);
      wb(1'b0, STATUS_OFS, '0);
      chk(rd, '0, 32'h7, "refused start");
    end
    $display("test illegal count done");
    wb(1'b1, COUNT_OFS, 32'h2);
    for (int nk = 0; nk < 2; nk++) begin
      wb(1'b1, CTRL_OFS, nk ? MODE | NACK_LAST : MODE | ACK_EN);
      u_far.send(EV_MRX, 0);
      chk_o(4'h0, 4'h7);
      wb(1'b0, STATUS_OFS, '0);
      chk(rd, 32'h0202, 32'h7F07, "mrx loaded");
      u_far.send(EV_BYTE, 0);
      chk_o(4'hA, 4'hF);
      u_far.send(EV_BYTE, 3);
      chk_o({nk == 0, 3'b001}, 4'hD);
    end
    $display("test master receive done");
    wb(1'b1, COUNT_OFS, 32'h3);
    u_far.send(EV_MTX, 0);
    for (int i = 1; i <= 3; i++) begin
      u_far.send(EV_BYTE, i);
      chk_o({3'b000, i == 3}, 4'h1);
    end
    wb(1'b0, STATUS_OFS, '0);
    chk(rd, '0, 32'h7, "mtx ended");
    $display("test master transmit done");
    wb(1'b1, COUNT_OFS, 32'h2);
    for (int nk = 0; nk < 2; nk++) begin
      wb(1'b1, CTRL_OFS, nk ? MODE | ACK_EN | NACK_LAST : MODE | ACK_EN);
      u_far.send(EV_SRX, 0);
      chk_o(4'hC, 4'hC);
      u_far.send(EV_BYTE, 1);
      chk_o(4'hE, 4'hE);
      u_far.send(EV_BYTE, 0);
      chk_o({nk == 0, 3'b100}, 4'hC);
      u_far.send(EV_STOP, 0);
      chk_o(4'h0, 4'h4);
    end
    $display("test slave receive done");
    // clearing the acknowledge bit mid-sequence lets the counted end drop the slave
    for (int d = 0; d < 2; d++) begin
      wb(1'b1, CTRL_OFS, MODE | ACK_EN);
      u_far.send(d ? EV_STX : EV_SRX, 0);
      chk_o(4'h4, 4'h4);
      u_far.send(EV_BYTE, 0);
      u_far.send(EV_BYTE, 0);
      chk_o(4'h4, 4'h4);
      wb(1'b1, CTRL_OFS, MODE);
      u_far.send(EV_BYTE, 0);
      chk_o(4'h4, 4'h4);
      u_far.send(EV_BYTE, 0);
      chk_o(4'h0, 4'h4);
    end
    $display("test slave drop done");
    // the ack value is still set from the last address, so a nack shows as a change
    wb(1'b1, CTRL_OFS, MODE | NACK_LAST);
    u_far.send(EV_SRX, 0);
    chk_o(4'h0, 4'hC);
    u_far.send(EV_STX, 0);
    chk_o(4'h0, 4'hC);
    $display("test address nack done");
    wb(1'b1, COUNT_OFS, 32'h3);
    wb(1'b1, CTRL_OFS, MODE | ACK_EN | NACK_LAST);
    u_far.send(EV_SRX, 0);
    u_far.send(EV_MTX, 0);
    chk_o(4'h4, 4'h4);
    u_far.send(EV_BYTE, 0);
    u_far.send(EV_STOP, 0);
    chk_o(4'h0, 4'h7);
    $display("test early stop done");
    end_sim;
  end
endmodule // test_i2c_buffered_ack_control
